/* hdl/thc_pkg.sv */
// package for the two-hand control logic: register map, timing, types
// assumes one 125 MHz bus clock and a 10 ms logic execution cycle
package thc_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [11:0] THC_CTRL_OFS = 12'h000;
   localparam logic [11:0] THC_TIMES_OFS = 12'h004;
   localparam logic [11:0] THC_STATUS_OFS = 12'h008;

   // control fields
   localparam int THC_CTRL_RUN_BIT = 0;
   localparam int THC_CTRL_FALL_BIT = 1;
   localparam int THC_CTRL_THREE_BIT = 2;
   localparam int THC_CTRL_NEN_LSB = 3;
   localparam logic [4:0] THC_CTRL_RST = 5'h00;
   localparam logic [1:0] THC_NEN_MAX = 2'h2;

   // per-pair synchronous windows, in logic cycles of 10 ms
   localparam int THC_TIMES_P2_LSB = 8;
   localparam logic [15:0] THC_TIMES_RST = 16'h3232;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int THC_CLK_KHZ = 125000;
   localparam int THC_CYCLE_MS = 10;
   localparam int THC_CYCLE_CLKS = THC_CYCLE_MS * THC_CLK_KHZ;
   localparam int THC_EQ_SYNC_MS = 500;
   localparam int THC_AGREE_MS = 500;
   localparam int THC_MAX_WIN_MS = 500;
   localparam logic [7:0] THC_EQ_SYNC_TICKS = 8'(THC_EQ_SYNC_MS / THC_CYCLE_MS);
   localparam logic [7:0] THC_AGREE_TICKS = 8'(THC_AGREE_MS / THC_CYCLE_MS);
   localparam logic [7:0] THC_MAX_WIN_TICKS = 8'(THC_MAX_WIN_MS / THC_CYCLE_MS);

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      THC_IDLE = 2'b00,
      THC_SYNC = 2'b01,
      THC_ACT = 2'b10,
      THC_LOCK = 2'b11
   } thc_ph_t;

   typedef struct packed
   {
      thc_ph_t ph;
      logic [7:0] timer;
      logic sync_err;
      logic seq_err;
   } thc_pair_t;

   typedef struct packed
   {
      logic eq_release;
      logic eq_sync_err;
      logic eq_seq_err;
      logic dp_release;
      logic dp_err_one;
      logic dp_err_two;
      logic mo_release;
   } thc_out_t;

   typedef struct packed
   {
      logic [1:0] eq_in;
      logic [3:0] dp_in;
      logic [2:0] hand_in;
      logic [1:0] enable_in;
      logic cycle_req;
   } thc_in_t;

endpackage

/* hdl/thc_top.sv */
// two-hand control logic: equivalent evaluator, double discrepant
// evaluator, multi-operator combiner, AHB-Lite register slave
// assumes synchronous inputs, a single slave on the bus, OKAY only
`timescale 1ns/1ns

module thc_top
#(
   parameter int CYCLE_CLKS = thc_pkg::THC_CYCLE_CLKS
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire thc_pkg::thc_in_t pins_in,
   output thc_pkg::thc_out_t pins_out
);
   import thc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic [31:0] tick_cnt;
      logic tick;
      logic [4:0] ctrl;
      logic [15:0] times;
      logic run_q;
      logic cyc_q;
      logic [2:0] low_seen;
      thc_pair_t eq;
      thc_pair_t pa;
      thc_pair_t pb;
      thc_pair_t grp;
      thc_out_t outs;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
   } thc_state_t;

   thc_state_t st_q;
   thc_state_t st_d;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // clamp a window to the allowed range, 0 stays off
   function automatic logic [7:0] win_clamp(logic [7:0] w);
      logic [7:0] r;
      r = w;
      if (w > THC_MAX_WIN_TICKS)
      begin
         r = THC_MAX_WIN_TICKS;
      end
      return r;
   endfunction

   // one logic cycle of a two-channel pair; a, b are channel-active
   function automatic thc_pair_t pair_step(thc_pair_t p, logic a,
                                           logic b, logic [7:0] lim);
      thc_pair_t n;
      n = p;
      case (p.ph)
         THC_IDLE:
         begin
            n.timer = 8'h01;
            if (a && b)
            begin
               n.ph = THC_ACT;
            end
            else if (a || b)
            begin
               n.ph = THC_SYNC;
            end
         end
         THC_SYNC:
         begin
            if (a && b)
            begin
               n.ph = THC_ACT;
            end
            else if (!a && !b)
            begin
               n.ph = THC_IDLE;
            end
            else if (lim != 8'h00 && p.timer >= lim)
            begin
               n.ph = THC_LOCK;
               n.sync_err = 1'b1;
            end
            else
            begin
               n.timer = p.timer + 8'h01;
            end
         end
         THC_ACT:
         begin
            if (!(a && b))
            begin
               n.ph = THC_LOCK;
            end
         end
         THC_LOCK:
         begin
            if (!a && !b)
            begin
               n.ph = THC_IDLE;
               n.sync_err = 1'b0;
               n.seq_err = 1'b0;
            end
            else if (a && b && !p.sync_err)
            begin
               n.seq_err = 1'b1;
            end
         end
         default:
         begin
            n.ph = THC_IDLE;
         end
      endcase
      return n;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [2:0] op_mask;
   logic [1:0] en_mask;
   logic start;
   logic cyc_edge;
   logic pa_on;
   logic pb_on;
   logic both_rel;
   logic rd_go;
   logic wr_go;
   logic [1:0] nen;
   thc_pair_t pair_idle;

   always_comb
   begin
      st_d = st_q;
      pair_idle = '0;
      nen = st_q.ctrl[THC_CTRL_NEN_LSB +: 2];
      if (nen > THC_NEN_MAX)
      begin
         nen = THC_NEN_MAX;
      end
      op_mask = st_q.ctrl[THC_CTRL_THREE_BIT] ? 3'h7 : 3'h3;
      en_mask = (nen == 2'h2) ? 2'h3 : ((nen == 2'h1) ? 2'h1 : 2'h0);
      start = st_q.ctrl[THC_CTRL_RUN_BIT] && !st_q.run_q;
      cyc_edge = st_q.ctrl[THC_CTRL_FALL_BIT]
         ? (st_q.cyc_q && !pins_in.cycle_req)
         : (!st_q.cyc_q && pins_in.cycle_req);
      pa_on = pins_in.dp_in[0] && !pins_in.dp_in[1];
      pb_on = pins_in.dp_in[2] && !pins_in.dp_in[3];
      both_rel = !pins_in.dp_in[0] && pins_in.dp_in[1]
         && !pins_in.dp_in[2] && pins_in.dp_in[3];
      rd_go = hsel && hready && htrans[1] && !hwrite;
      wr_go = hsel && hready && htrans[1] && hwrite;

      // logic execution cycle
      st_d.tick = 1'b0;
      if (st_q.tick_cnt >= 32'(CYCLE_CLKS - 1))
      begin
         st_d.tick_cnt = '0;
         st_d.tick = 1'b1;
      end
      else
      begin
         st_d.tick_cnt = st_q.tick_cnt + 32'h1;
      end

      if (!st_q.ctrl[THC_CTRL_RUN_BIT])
      begin
         st_d.run_q = 1'b0;
         st_d.eq = pair_idle;
         st_d.pa = pair_idle;
         st_d.pb = pair_idle;
         st_d.grp = pair_idle;
         st_d.low_seen = '0;
         st_d.outs = '0;
         st_d.cyc_q = pins_in.cycle_req;
      end
      else if (st_q.tick)
      begin
         st_d.run_q = 1'b1;
         st_d.cyc_q = pins_in.cycle_req;

         // equivalent pair, fixed 500 ms
         st_d.eq = pair_step(st_q.eq, pins_in.eq_in[0], pins_in.eq_in[1],
                             THC_EQ_SYNC_TICKS);
         st_d.outs.eq_release = (st_d.eq.ph == THC_ACT);
         st_d.outs.eq_sync_err = st_d.eq.sync_err;
         st_d.outs.eq_seq_err = st_d.eq.seq_err;

         // two discrepant pairs with own windows
         st_d.pa = pair_step(st_q.pa, pins_in.dp_in[0], !pins_in.dp_in[1],
                             win_clamp(st_q.times[7:0]));
         st_d.pb = pair_step(st_q.pb, pins_in.dp_in[2], !pins_in.dp_in[3],
                             win_clamp(st_q.times[THC_TIMES_P2_LSB +: 8]));
         st_d.outs.dp_err_one = st_d.pa.sync_err;
         st_d.outs.dp_err_two = st_d.pb.sync_err;

         // agreement window between pairs, never an error
         case (st_q.grp.ph)
            THC_IDLE:
            begin
               st_d.grp.timer = 8'h01;
               if (!both_rel)
               begin
                  st_d.grp.ph = THC_SYNC;
               end
            end
            THC_SYNC:
            begin
               if (both_rel)
               begin
                  st_d.grp.ph = THC_IDLE;
               end
               else if (pa_on && pb_on && st_q.pa.ph != THC_LOCK
                        && st_q.pb.ph != THC_LOCK)
               begin
                  st_d.grp.ph = THC_ACT;
               end
               else if (st_q.grp.timer >= THC_AGREE_TICKS)
               begin
                  st_d.grp.ph = THC_LOCK;
               end
               else
               begin
                  st_d.grp.timer = st_q.grp.timer + 8'h01;
               end
            end
            THC_ACT:
            begin
               if (!(pa_on && pb_on))
               begin
                  st_d.grp.ph = THC_LOCK;
               end
            end
            THC_LOCK:
            begin
               if (both_rel)
               begin
                  st_d.grp.ph = THC_IDLE;
               end
            end
            default:
            begin
               st_d.grp.ph = THC_IDLE;
            end
         endcase
         st_d.outs.dp_release = (st_d.grp.ph == THC_ACT)
            && (st_d.pa.ph == THC_ACT) && (st_d.pb.ph == THC_ACT);

         // multi-operator combiner
         if (start || cyc_edge)
         begin
            st_d.low_seen = '0;
         end
         else
         begin
            st_d.low_seen = st_q.low_seen | ~pins_in.hand_in;
         end
         st_d.outs.mo_release = !start && !cyc_edge
            && ((pins_in.enable_in & en_mask) == en_mask)
            && ((pins_in.hand_in & op_mask) == op_mask)
            && ((st_q.low_seen & op_mask) == op_mask);
      end

      // bus: capture address phase, write in data phase
      st_d.wr_pend = wr_go;
      if (wr_go)
      begin
         st_d.wr_addr = haddr;
      end
      if (st_q.wr_pend)
      begin
         case (st_q.wr_addr)
            THC_CTRL_OFS: st_d.ctrl = hwdata[4:0];
            THC_TIMES_OFS: st_d.times = hwdata[15:0];
            default: st_d.ctrl = st_q.ctrl;
         endcase
      end
      if (rd_go)
      begin
         case (haddr)
            THC_CTRL_OFS: st_d.rdata = {27'h0, st_q.ctrl};
            THC_TIMES_OFS: st_d.rdata = {16'h0, st_q.times};
            THC_STATUS_OFS: st_d.rdata = {21'h0, st_q.low_seen,
                                          1'b0, st_q.outs};
            default: st_d.rdata = 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= '0;
         st_q.ctrl <= THC_CTRL_RST;
         st_q.times <= THC_TIMES_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign hrdata = st_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pins_out = st_q.outs;

endmodule

/* verif/thc_top_asserts.sv */
// checker for the two-hand control top: output timing against inputs
// assumes CYCLE_CLKS of 4, so four edges always hold one tick edge
`timescale 1ns/1ns
module thc_top_asserts
   import thc_pkg::*;
#(
   parameter int CYCLE_CLKS = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire thc_pkg::thc_in_t pins_in,
   input wire thc_pkg::thc_out_t pins_out
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_eq_rel_pair: assert property (
      $rose(pins_out.eq_release) |-> $past(pins_in.eq_in) == 2'b11)
      else $error("equivalent release rose without both channels");
   a_eq_rel_drop: assert property (
      (pins_in.eq_in != 2'b11) [*4] |=> !pins_out.eq_release)
      else $error("equivalent release held after a tick");
   a_eq_err_clear: assert property (
      (pins_in.eq_in == 2'b00) [*4] |=>
      !pins_out.eq_sync_err && !pins_out.eq_seq_err)
      else $error("equivalent errors kept after full release");
   a_eq_err_excl: assert property (
      pins_out.eq_release |-> !pins_out.eq_sync_err && !pins_out.eq_seq_err)
      else $error("equivalent release together with an error");
   a_dp_rel_pair: assert property (
      $rose(pins_out.dp_release) |-> $past(pins_in.dp_in) == 4'h5)
      else $error("double release rose without both pairs active");
   a_dp_rel_drop: assert property (
      (pins_in.dp_in != 4'h5) [*4] |=> !pins_out.dp_release)
      else $error("double release held after a tick");
   a_mo_rel_hands: assert property (
      $rose(pins_out.mo_release) |-> $past(pins_in.hand_in[1:0]) == 2'b11)
      else $error("combined release rose without both hands");
   a_mo_hand_drop: assert property (
      (!pins_in.hand_in[0]) [*4] |=> !pins_out.mo_release)
      else $error("combined release held with a hand low");
   a_unmapped_read: assert property (hsel && hready && htrans[1] &&
      !hwrite && haddr == 12'hFFC |=> hrdata == 32'h0)
      else $error("unmapped read not zero");

   c_eq_rel: cover property ($rose(pins_out.eq_release));
   c_dp_rel: cover property ($rose(pins_out.dp_release));
   c_mo_rel: cover property ($rose(pins_out.mo_release));
endmodule

bind thc_top thc_top_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .pins_in(pins_in),
   .pins_out(pins_out)
);

/* verif/thc_operator_model.sv */
// operator side model: buttons and upstream evaluators as input levels
// assumes the bench hands it a command word and a lag in clocks
`timescale 1ns/1ns
module thc_operator_model
   import thc_pkg::*;
(
   input wire logic hclk,
   input wire thc_pkg::thc_in_t cmd,
   input wire logic [1:0] lag,
   output thc_pkg::thc_in_t pins
);
   thc_in_t want_q;
   logic [1:0] cnt_q;

   initial
   begin
      pins = '0;
      want_q = '0;
      cnt_q = 2'h0;
   end

   // hand inputs carry pre-evaluated release levels only
   always @(posedge hclk)
   begin
      if (cmd !== want_q)
      begin
         want_q <= cmd;
         cnt_q <= lag;
      end
      else if (cnt_q != 2'h0)
         cnt_q <= cnt_q - 2'h1;
      else
         pins <= want_q;
   end
endmodule

/* verif/thc_top_tb_top.sv */
// self-checking bench for the two-hand control top
// assumes CYCLE_CLKS of 4 and a single AHB-Lite slave
`timescale 1ns/1ns
module thc_top_tb_top;
   import thc_pkg::*;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} thc_note_t;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_phase, rnd_h2;
   logic [11:0] haddr;
   logic [1:0] htrans, lag;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, seed, r;
   logic [7:0] b1, b2;
   thc_in_t pins_in, cmd;
   thc_out_t pins_out;
   int miscompares, num_checks;
   thc_note_t notes[$];

   thc_top #(.CYCLE_CLKS(4)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pins_in(pins_in),
      .pins_out(pins_out));
   thc_operator_model u_ops (.hclk(hclk), .cmd(cmd), .lag(lag),
      .pins(pins_in));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] cl(input logic [7:0] b);
      return (b > 8'h32) ? 8'h32 : b;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_phase <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] m, input string nm);
      notes.push_back('{nm, e, m});
      bus(1'b0, a, 32'h0);
   endtask

   // set operator inputs, let t ticks pass, expect status[6:0]
   task automatic op(input logic [1:0] eq, input logic [3:0] dp,
      input logic [2:0] h, input logic [1:0] en, input logic cr,
      input int t, input logic [6:0] e);
      logic [31:0] q;
      thc_in_t x;
      q = xs();
      x = {eq, dp, h, en, cr};
      if (rnd_h2)
         x.hand_in[2] = q[4];
      cmd <= x;
      lag <= q[1:0];
      // count ticks only once the model shows the new levels
      do @(posedge hclk); while (pins_in !== x);
      repeat (4 * t) @(posedge hclk);
      rd(THC_STATUS_OFS, {25'h0, e}, 32'h7F, "outputs");
   endtask

   task automatic summarize();
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, monitor, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      thc_note_t n;
      if (rd_phase === 1'b1 && hreadyout === 1'b1)
      begin
         n = notes.pop_front();
         check(n.nm, hrdata & n.m, n.e & n.m);
      end
   end

   initial
   begin
      repeat (30000) @(posedge hclk);
      miscompares++;
      summarize();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {hresetn, hsel, hwrite, rd_phase, htrans, haddr} = '0;
      {hwdata, miscompares, num_checks} = '0;
      hsize = 3'h2;
      rnd_h2 = 1'b1;
      seed = 32'hFD61B834;
      cmd = {2'b00, 4'hA, 3'h0, 2'h0, 1'b0};
      lag = 2'h0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(THC_CTRL_OFS, 32'h0, 32'hFFFFFFFF, "ctrl");
      rd(THC_TIMES_OFS, 32'h3232, 32'hFFFFFFFF, "times");
      bus(1'b1, 12'hFFC, 32'hFFFFFFFF);
      rd(12'hFFC, 32'h0, 32'hFFFFFFFF, "unmapped");
      bus(1'b1, THC_STATUS_OFS, 32'h7F);
      r = xs();
      b1 = r[7:0] | 8'h01;
      b2 = r[15:8] | 8'h01;
      bus(1'b1, THC_TIMES_OFS, {16'h0, b2, b1});
      rd(THC_TIMES_OFS, {16'h0, b2, b1}, 32'hFFFF, "times");
      bus(1'b1, THC_CTRL_OFS, 32'h1);
      rd(THC_CTRL_OFS, 32'h1, 32'h1F, "ctrl");
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(3, 10, 0, 0, 0, 2, 'h40);
      op(2, 10, 0, 0, 0, 2, 'h00);
      op(3, 10, 0, 0, 0, 2, 'h10);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(1, 10, 0, 0, 0, 45, 'h00);
      op(3, 10, 0, 0, 0, 2, 'h40);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(1, 10, 0, 0, 0, 55, 'h20);
      op(3, 10, 0, 0, 0, 2, 'h20);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 5, 0, 0, 0, 2, 'h08);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 9, 0, 0, 0, 55, 'h00);
      op(0, 5, 0, 0, 0, 2, 'h00);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 5, 0, 0, 0, 2, 'h08);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 8, 0, 0, 0, int'(cl(b1)) + 3, 'h04);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 2, 0, 0, 0, int'(cl(b2)) + 3, 'h02);
      op(0, 10, 0, 0, 0, 2, 'h00);
      bus(1'b1, THC_TIMES_OFS, 32'h0);
      op(0, 8, 0, 0, 0, 55, 'h00);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 10, 3, 0, 0, 2, 'h01);
      op(0, 10, 3, 0, 1, 2, 'h00);
      rd(THC_STATUS_OFS, 32'h0, 32'h300, "low seen");
      op(0, 10, 0, 0, 1, 2, 'h00);
      op(0, 10, 3, 0, 1, 2, 'h01);
      bus(1'b1, THC_CTRL_OFS, 32'h3);
      op(0, 10, 3, 0, 0, 2, 'h00);
      op(0, 10, 0, 0, 0, 2, 'h00);
      op(0, 10, 3, 0, 0, 2, 'h01);
      bus(1'b1, THC_CTRL_OFS, 32'h11);
      op(0, 10, 0, 1, 0, 2, 'h00);
      op(0, 10, 3, 1, 0, 2, 'h00);
      op(0, 10, 3, 3, 0, 2, 'h01);
      op(0, 10, 3, 2, 0, 2, 'h00);
      op(0, 10, 3, 3, 0, 2, 'h01);
      bus(1'b1, THC_CTRL_OFS, 32'h9);
      op(0, 10, 3, 1, 0, 2, 'h01);
      op(0, 10, 3, 2, 0, 2, 'h00);
      bus(1'b1, THC_CTRL_OFS, 32'h19);
      rd(THC_CTRL_OFS, 32'h19, 32'h1F, "ctrl");
      op(0, 10, 3, 1, 0, 2, 'h00);
      op(0, 10, 3, 3, 0, 2, 'h01);
      bus(1'b1, THC_CTRL_OFS, 32'h0);
      repeat (4) @(posedge hclk);
      rd(THC_STATUS_OFS, 32'h0, 32'h7F, "stopped");
      rnd_h2 = 1'b0;
      bus(1'b1, THC_CTRL_OFS, 32'h5);
      op(0, 10, 4, 0, 0, 2, 'h00);
      op(0, 10, 7, 0, 0, 2, 'h00);
      op(0, 10, 3, 0, 0, 2, 'h00);
      op(0, 10, 7, 0, 0, 2, 'h01);
      summarize();
   end
endmodule
